// ### hw/oscctl_pkg.sv
// Purpose: constants shared by the oscillator control register block
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes: printed offsets are not multiples of four, so they are indices
//
// Operation
// - internal oscillator enable is bit 7 of the internal control register.
// - bit 6 of the internal control register reads 1 only at frequency.
// - the six low internal control bits read 001111 and are written so.
// - bit 7 of the trim register turns on dithering and resets to 0.
// - the low seven trim bits reset to a factory value for nominal speed.
// - a larger trim lowers the frequency, about one percent per step.
// - bit 7 of the external control register reads 1 when stable.
// - in either CMOS clock mode the stable flag always reads 0.
// - bits 6 to 4 select the external oscillator mode.
// - bit 3 of the external control register reads 0, written as 0.
// - the low three external bits hold the bias code, all values legal.
package oscctl_pkg;

   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] OSCCTL_IDX_EXT = 8'hb1;
   localparam logic [7:0] OSCCTL_IDX_INT = 8'hb2;
   localparam logic [7:0] OSCCTL_IDX_TRIM = 8'hb3;
   localparam logic [7:0] OSCCTL_IDX_IRQ_STAT = 8'hb4;
   localparam logic [7:0] OSCCTL_IDX_IRQ_MASK = 8'hb5;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int OSCCTL_INT_ON_BIT = 7;
   localparam int OSCCTL_INT_OK_BIT = 6;
   localparam logic [5:0] OSCCTL_INT_RSVD = 6'h0f;
   localparam int OSCCTL_DITHER_BIT = 7;
   localparam logic [6:0] OSCCTL_TRIM_FACTORY = 7'h40;
   localparam int OSCCTL_EXT_STABLE_BIT = 7;
   localparam int OSCCTL_KIND_LSB = 4;
   localparam int OSCCTL_BIAS_LSB = 0;

   // interrupt status bits
   localparam int OSCCTL_IRQ_INT_OK = 0;
   localparam int OSCCTL_IRQ_EXT_OK = 1;
   localparam int OSCCTL_IRQ_W = 2;

   // ---------------------------------------------------------------
   // external oscillator modes
   // ---------------------------------------------------------------
   localparam logic [2:0] OSCCTL_KIND_OFF0 = 3'h0;
   localparam logic [2:0] OSCCTL_KIND_OFF1 = 3'h1;
   localparam logic [2:0] OSCCTL_KIND_CMOS = 3'h2;
   localparam logic [2:0] OSCCTL_KIND_CMOS_DIV2 = 3'h3;
   localparam logic [2:0] OSCCTL_KIND_RC = 3'h4;
   localparam logic [2:0] OSCCTL_KIND_CAP = 3'h5;
   localparam logic [2:0] OSCCTL_KIND_XTAL = 3'h6;
   localparam logic [2:0] OSCCTL_KIND_XTAL_DIV2 = 3'h7;

   // ---------------------------------------------------------------
   // ahb encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] OSCCTL_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] OSCCTL_HSIZE_WORD = 3'h2;

   // settle counts in system clocks after the analog side reports ready
   localparam int OSCCTL_SETTLE_W = 4;
   localparam logic [3:0] OSCCTL_SETTLE_CYC = 4'h8;

endpackage

// ### hw/oscctl_settle.sv
// Purpose: filter an analog ready level into a stable flag
// Assumes: raw ready is synchronous to clk_in
// Notes: flag drops on the next clk_in edge when raw ready or enable goes away
`timescale 1ns/1ps
module oscctl_settle
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // level in
   input wire logic enable_in,
   input wire logic raw_ok_in,
   // level out
   output logic ok_out
);

   logic [oscctl_pkg::OSCCTL_SETTLE_W-1:0] count;
   logic [oscctl_pkg::OSCCTL_SETTLE_W-1:0] next_count;
   logic ok;
   logic next_ok;

   // ---------------------------------------------------------------
   // settle counter
   // ---------------------------------------------------------------
   always_comb
   begin
      next_count = count;
      next_ok = 1'b0;
      if (!(enable_in && raw_ok_in))
      begin
         next_count = '0;
      end
      else if (count == oscctl_pkg::OSCCTL_SETTLE_CYC)
      begin
         next_ok = 1'b1;
      end
      else
      begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count <= '0;
         ok <= 1'b0;
      end
      else
      begin
         count <= next_count;
         ok <= next_ok;
      end
   end

   assign ok_out = ok;

endmodule

// ### hw/oscctl_div2.sv
// Purpose: optional divide-by-2 of the external clock level
// Assumes: ext clock level sampled synchronously, well below clk_in
// Notes: toggles on each rising edge of the sampled input
`timescale 1ns/1ps
module oscctl_div2
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control and clock level in
   input wire logic enable_in,
   input wire logic div2_in,
   input wire logic ext_clk_in,
   // clock level out
   output logic clk_out
);

   logic prev;
   logic next_prev;
   logic half;
   logic next_half;
   logic out;
   logic next_out;

   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   always_comb
   begin
      next_prev = ext_clk_in;
      next_half = half;
      if (!enable_in)
      begin
         next_half = 1'b0;
      end
      else if (ext_clk_in && !prev)
      begin
         next_half = !half;
      end
      next_out = 1'b0;
      if (enable_in)
      begin
         next_out = div2_in ? half : ext_clk_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prev <= 1'b0;
         half <= 1'b0;
         out <= 1'b0;
      end
      else
      begin
         prev <= next_prev;
         half <= next_half;
         out <= next_out;
      end
   end

   assign clk_out = out;

endmodule

// ### hw/oscctl_regs.sv
// Purpose: oscillator control and status registers on AHB-Lite
// Assumes: single word transfers, one clock domain at 40 MHz
// Notes: zero wait states, response always OKAY, unmapped reads zero
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module oscctl_regs
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // analog status
   input wire logic int_osc_ready_in,
   input wire logic ext_osc_ready_in,
   input wire logic ext_clk_in,
   // analog controls
   output logic int_osc_on_out,
   output logic dither_on_out,
   output logic [6:0] int_osc_trim_out,
   output logic [2:0] ext_osc_kind_out,
   output logic [2:0] ext_osc_bias_out,
   output logic ext_clk_out,
   // interrupt
   output logic irq_out
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic int_osc_on;
   logic next_int_osc_on;
   logic dither_on;
   logic next_dither_on;
   logic [6:0] int_osc_trim;
   logic [6:0] next_int_osc_trim;
   logic [2:0] ext_osc_kind;
   logic [2:0] next_ext_osc_kind;
   logic [2:0] ext_osc_bias;
   logic [2:0] next_ext_osc_bias;
   logic [oscctl_pkg::OSCCTL_IRQ_W-1:0] irq_stat;
   logic [oscctl_pkg::OSCCTL_IRQ_W-1:0] next_irq_stat;
   logic [oscctl_pkg::OSCCTL_IRQ_W-1:0] irq_mask;
   logic [oscctl_pkg::OSCCTL_IRQ_W-1:0] next_irq_mask;
   logic irq;
   logic next_irq;
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   // pending write from the address phase
   logic wr_pend;
   logic next_wr_pend;
   logic [7:0] wr_idx;
   logic [7:0] next_wr_idx;

   logic int_ok;
   logic ext_ok;
   logic int_ok_d;
   logic ext_ok_d;
   logic ext_clk_div;
   logic ext_running;
   logic ext_is_cmos;
   logic ext_div2;

   logic addr_ok;
   logic [7:0] addr_idx;
   logic [7:0] rd_byte;
   logic [oscctl_pkg::OSCCTL_IRQ_W-1:0] rise;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_cmos(input logic [2:0] kind);
      is_cmos = (kind == oscctl_pkg::OSCCTL_KIND_CMOS) ||
                (kind == oscctl_pkg::OSCCTL_KIND_CMOS_DIV2);
   endfunction

   function automatic logic is_off(input logic [2:0] kind);
      is_off = (kind == oscctl_pkg::OSCCTL_KIND_OFF0) ||
               (kind == oscctl_pkg::OSCCTL_KIND_OFF1);
   endfunction

   // external modes: 00x off, 010/011 cmos, 100 rc, 101 cap, 11x xtal
   assign ext_is_cmos = is_cmos(ext_osc_kind);
   assign ext_running = !is_off(ext_osc_kind);
   assign ext_div2 = (ext_osc_kind == oscctl_pkg::OSCCTL_KIND_CMOS_DIV2) ||
                     (ext_osc_kind == oscctl_pkg::OSCCTL_KIND_XTAL_DIV2);

   // ---------------------------------------------------------------
   // status filters and external clock path
   // ---------------------------------------------------------------
   oscctl_settle u_int_settle
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(int_osc_on),
      .raw_ok_in(int_osc_ready_in),
      .ok_out(int_ok)
   );

   // cmos modes have no detector, so the filter is held off there
   oscctl_settle u_ext_settle
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(ext_running && !ext_is_cmos),
      .raw_ok_in(ext_osc_ready_in),
      .ok_out(ext_ok)
   );

   oscctl_div2 u_div2
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(ext_running && ext_osc_kind != oscctl_pkg::OSCCTL_KIND_RC &&
                 ext_osc_kind != oscctl_pkg::OSCCTL_KIND_CAP),
      .div2_in(ext_div2),
      .ext_clk_in(ext_clk_in),
      .clk_out(ext_clk_div)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign addr_idx = haddr_in[9:2];
   assign addr_ok = hsel_in && hready_in &&
                    htrans_in == oscctl_pkg::OSCCTL_HTRANS_NONSEQ;

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (addr_idx)
         oscctl_pkg::OSCCTL_IDX_EXT:
         begin
            rd_byte = {ext_ok && !ext_is_cmos, ext_osc_kind, 1'b0,
                       ext_osc_bias};
         end
         oscctl_pkg::OSCCTL_IDX_INT:
         begin
            rd_byte = {int_osc_on, int_ok && int_osc_on,
                       oscctl_pkg::OSCCTL_INT_RSVD};
         end
         oscctl_pkg::OSCCTL_IDX_TRIM:
         begin
            rd_byte = {dither_on, int_osc_trim};
         end
         oscctl_pkg::OSCCTL_IDX_IRQ_STAT:
         begin
            rd_byte = {6'h00, irq_stat};
         end
         oscctl_pkg::OSCCTL_IDX_IRQ_MASK:
         begin
            rd_byte = {6'h00, irq_mask};
         end
         default:
         begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // register next values
   // ---------------------------------------------------------------
   assign rise = {ext_ok && !ext_ok_d, int_ok && !int_ok_d};

   always_comb
   begin
      next_int_osc_on = int_osc_on;
      next_dither_on = dither_on;
      next_int_osc_trim = int_osc_trim;
      next_ext_osc_kind = ext_osc_kind;
      next_ext_osc_bias = ext_osc_bias;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_rdata = rdata;
      next_wr_pend = addr_ok && hwrite_in;
      next_wr_idx = addr_ok ? addr_idx : wr_idx;
      if (addr_ok && !hwrite_in)
      begin
         next_rdata = {24'h000000, rd_byte};
         // read of status clears it
         if (addr_idx == oscctl_pkg::OSCCTL_IDX_IRQ_STAT)
         begin
            next_irq_stat = '0;
         end
      end
      if (wr_pend)
      begin
         unique case (wr_idx)
            oscctl_pkg::OSCCTL_IDX_EXT:
            begin
               // stable flag and bit 3 ignore writes
               next_ext_osc_kind = hwdata_in[6:4];
               next_ext_osc_bias = hwdata_in[2:0];
            end
            oscctl_pkg::OSCCTL_IDX_INT:
            begin
               // reserved low bits are fixed, not stored
               next_int_osc_on = hwdata_in[7];
            end
            oscctl_pkg::OSCCTL_IDX_TRIM:
            begin
               next_dither_on = hwdata_in[7];
               // larger code slows the oscillator, decoded in analog
               next_int_osc_trim = hwdata_in[6:0];
            end
            oscctl_pkg::OSCCTL_IDX_IRQ_MASK:
            begin
               next_irq_mask = hwdata_in[oscctl_pkg::OSCCTL_IRQ_W-1:0];
            end
            default:
            begin
            end
         endcase
      end
      // new events win over a clearing read
      next_irq_stat = next_irq_stat | rise;
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         int_osc_on <= 1'b0;
         dither_on <= 1'b0;
         int_osc_trim <= oscctl_pkg::OSCCTL_TRIM_FACTORY;
         ext_osc_kind <= oscctl_pkg::OSCCTL_KIND_OFF0;
         ext_osc_bias <= 3'h0;
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
         rdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         int_ok_d <= 1'b0;
         ext_ok_d <= 1'b0;
      end
      else
      begin
         int_osc_on <= next_int_osc_on;
         dither_on <= next_dither_on;
         int_osc_trim <= next_int_osc_trim;
         ext_osc_kind <= next_ext_osc_kind;
         ext_osc_bias <= next_ext_osc_bias;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
         rdata <= next_rdata;
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
         int_ok_d <= int_ok;
         ext_ok_d <= ext_ok && !ext_is_cmos;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hrdata_out = rdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign int_osc_on_out = int_osc_on;
   assign dither_on_out = dither_on;
   assign int_osc_trim_out = int_osc_trim;
   assign ext_osc_kind_out = ext_osc_kind;
   assign ext_osc_bias_out = ext_osc_bias;
   assign ext_clk_out = ext_clk_div;
   assign irq_out = irq;

endmodule

// ### verif/oscctl_chk.sv
// Purpose: port-level checks for oscctl_regs
// Assumes: one slave, hready_in tied to hreadyout_out
// Notes: bound to every oscctl_regs instance
`timescale 1ns/1ps
module oscctl_chk
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // ahb-lite
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   // analog side
   input wire logic int_osc_ready_in,
   input wire logic ext_osc_ready_in,
   input wire logic ext_clk_in,
   input wire logic int_osc_on_out,
   input wire logic dither_on_out,
   input wire logic [6:0] int_osc_trim_out,
   input wire logic [2:0] ext_osc_kind_out,
   input wire logic [2:0] ext_osc_bias_out,
   input wire logic ext_clk_out,
   input wire logic irq_out
);
   localparam logic [7:0] IX_EXT = oscctl_pkg::OSCCTL_IDX_EXT;
   localparam logic [7:0] IX_INT = oscctl_pkg::OSCCTL_IDX_INT;
   localparam logic [7:0] IX_TRIM = oscctl_pkg::OSCCTL_IDX_TRIM;
   // ----------------------------------------
   // data-phase tracking
   // ----------------------------------------
   logic wr, rd, next_wr, next_rd;
   logic [7:0] idx, next_idx;
   always_comb
   begin
      next_wr = hsel_in && hready_in && hwrite_in
         && htrans_in == oscctl_pkg::OSCCTL_HTRANS_NONSEQ;
      next_rd = hsel_in && hready_in && !hwrite_in
         && htrans_in == oscctl_pkg::OSCCTL_HTRANS_NONSEQ;
      next_idx = haddr_in[9:2];
   end
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr <= 1'b0;
         rd <= 1'b0;
         idx <= 8'h00;
      end
      else
      begin
         wr <= next_wr;
         rd <= next_rd;
         idx <= next_idx;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   chk_on_write: assert property (wr && idx == IX_INT
      |=> int_osc_on_out == $past(hwdata_in[7]))
      else $error("enable output not taken from write");
   chk_dither_write: assert property (wr && idx == IX_TRIM
      |=> dither_on_out == $past(hwdata_in[7]))
      else $error("dither output not taken from write");
   chk_trim_write: assert property (wr && idx == IX_TRIM
      |=> int_osc_trim_out == $past(hwdata_in[6:0]))
      else $error("trim output not taken from write");
   chk_kind_write: assert property (wr && idx == IX_EXT
      |=> ext_osc_kind_out == $past(hwdata_in[6:4]))
      else $error("mode output not taken from write");
   chk_bias_write: assert property (wr && idx == IX_EXT
      |=> ext_osc_bias_out == $past(hwdata_in[2:0]))
      else $error("bias output not taken from write");
   chk_int_readback: assert property (rd && idx == IX_INT
      |-> hrdata_out[5:0] == 6'h0f && hrdata_out[7] == int_osc_on_out)
      else $error("internal control read wrong");
   chk_freq_ok: assert property (rd && idx == IX_INT
      && hrdata_out[6] |-> $past(int_osc_ready_in, 4) && hrdata_out[7])
      else $error("frequency flag without ready oscillator");
   chk_ext_fields: assert property (rd && idx == IX_EXT
      |-> !hrdata_out[3] && hrdata_out[6:4] == ext_osc_kind_out)
      else $error("external control read wrong");
   chk_ext_cmos: assert property (rd && idx == IX_EXT
      && ext_osc_kind_out[2:1] == 2'b01 |-> !hrdata_out[7])
      else $error("stable flag set in clock input mode");
   chk_ext_unused: assert property (rd && idx == IX_EXT
      && hrdata_out[7] |-> ext_osc_kind_out[2]
      && $past(ext_osc_ready_in, 4))
      else $error("stable flag set while unused or unready");
   cover property (rd && idx == IX_INT && hrdata_out[6]);
   cover property (rd && idx == IX_EXT && hrdata_out[7]);
   cover property ($rose(irq_out));
   cover property (wr && idx == IX_EXT && hwdata_in[6:4] == 3'h7);
endmodule

bind oscctl_regs oscctl_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
   .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
   .hready_in(hready_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .int_osc_ready_in(int_osc_ready_in),
   .ext_osc_ready_in(ext_osc_ready_in), .ext_clk_in(ext_clk_in),
   .int_osc_on_out(int_osc_on_out), .dither_on_out(dither_on_out),
   .int_osc_trim_out(int_osc_trim_out),
   .ext_osc_kind_out(ext_osc_kind_out),
   .ext_osc_bias_out(ext_osc_bias_out), .ext_clk_out(ext_clk_out),
   .irq_out(irq_out));

// ### verif/oscctl_regs_tb.sv
// Purpose: self-checking bench for oscctl_regs
// Assumes: ahb master holds each phase until hready is seen high
// Notes: fixed seed, so every run draws the same values
`timescale 1ns/1ps
module oscctl_regs_tb;
   localparam logic [7:0] IX_EXT = oscctl_pkg::OSCCTL_IDX_EXT;
   localparam logic [7:0] IX_INT = oscctl_pkg::OSCCTL_IDX_INT;
   localparam logic [7:0] IX_TRIM = oscctl_pkg::OSCCTL_IDX_TRIM;
   localparam logic [7:0] IX_STAT = oscctl_pkg::OSCCTL_IDX_IRQ_STAT;
   localparam logic [7:0] IX_MASK = oscctl_pkg::OSCCTL_IDX_IRQ_MASK;
   logic clk_in, rst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
   logic [31:0] haddr_in, hwdata_in, hrdata_out, rd, d;
   logic [1:0] htrans_in;
   logic [2:0] hsize_in, ext_osc_kind_out, ext_osc_bias_out;
   logic int_osc_ready_in, ext_osc_ready_in, ext_clk_in, int_osc_on_out;
   logic dither_on_out, ext_clk_out, irq_out, prev_clk;
   logic [6:0] int_osc_trim_out;
   integer mismatches, comparisons, seed, rises, base, k;

   oscctl_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
      .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
      .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
      .int_osc_ready_in(int_osc_ready_in),
      .ext_osc_ready_in(ext_osc_ready_in), .ext_clk_in(ext_clk_in),
      .int_osc_on_out(int_osc_on_out), .dither_on_out(dither_on_out),
      .int_osc_trim_out(int_osc_trim_out),
      .ext_osc_kind_out(ext_osc_kind_out),
      .ext_osc_bias_out(ext_osc_bias_out), .ext_clk_out(ext_clk_out),
      .irq_out(irq_out));

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // ----------------------------------------
   // tasks and expectations
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one single word transfer; read data lands in rd
   task automatic xfer(input logic [7:0] idx, input logic wr,
      input logic [31:0] wd);
      hsel_in <= 1'b1;
      haddr_in <= {22'h0, idx, 2'b00};
      htrans_in <= oscctl_pkg::OSCCTL_HTRANS_NONSEQ;
      hwrite_in <= wr;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      rd = hrdata_out;
   endtask

   function automatic logic [31:0] exp_int(input logic on, input logic ok);
      return {24'h0, on, on & ok, 6'h0f};
   endfunction

   // stable only in the oscillator modes, never for a clock input
   function automatic logic [31:0] exp_ext(input logic [7:0] v,
      input logic r);
      return {24'h0, r & v[6], v[6:4], 1'b0, v[2:0]};
   endfunction

   always @(posedge clk_in)
   begin
      if (ext_clk_out === 1'b1 && prev_clk === 1'b0)
         rises = rises + 1;
      prev_clk = ext_clk_out;
   end

   // watchdog sized well above the roughly 730 cycles of the run
   initial
   begin
      #250000;
      mismatches++;
      end_sim;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      mismatches = 0;
      comparisons = 0;
      rises = 0;
      seed = 32'h9712f027;
      rst_n_in = 1'b0;
      hsel_in = 1'b0;
      haddr_in = 32'h0;
      htrans_in = 2'h0;
      hwrite_in = 1'b0;
      hsize_in = oscctl_pkg::OSCCTL_HSIZE_WORD;
      hwdata_in = 32'h0;
      int_osc_ready_in = 1'b0;
      ext_osc_ready_in = 1'b0;
      ext_clk_in = 1'b0;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      xfer(IX_INT, 1'b0, 32'h0);
      check("int reset", rd, 32'h0f);
      xfer(IX_EXT, 1'b0, 32'h0);
      check("ext reset", rd, 32'h00);
      xfer(IX_TRIM, 1'b0, 32'h0);
      check("trim reset", rd, 32'h40);
      // masked event: status sets, line stays low
      xfer(IX_MASK, 1'b1, 32'h0);
      xfer(IX_INT, 1'b0, 32'h0);
      xfer(IX_INT, 1'b1, rd | 32'h80);
      // the write lands on the closing edge, so look one edge later
      @(posedge clk_in);
      check("on out", 32'(int_osc_on_out), 32'h1);
      int_osc_ready_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      xfer(IX_INT, 1'b0, 32'h0);
      check("int ready", rd, exp_int(1'b1, 1'b1));
      check("irq masked", 32'(irq_out), 32'h0);
      xfer(IX_STAT, 1'b0, 32'h0);
      check("status", rd, 32'h1);
      xfer(IX_MASK, 1'b1, 32'h3);
      int_osc_ready_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      xfer(IX_INT, 1'b0, 32'h0);
      check("int not ready", rd, exp_int(1'b1, 1'b0));
      int_osc_ready_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      check("irq raised", 32'(irq_out), 32'h1);
      xfer(IX_STAT, 1'b0, 32'h0);
      repeat (2) @(posedge clk_in);
      check("irq cleared", 32'(irq_out), 32'h0);
      // off, reserved bits written as the fixed pattern
      xfer(IX_INT, 1'b1, 32'h0f);
      xfer(IX_INT, 1'b0, 32'h0);
      check("int off", rd, exp_int(1'b0, 1'b1));
      // trim: both extremes, then random, read back to back
      for (k = 0; k < 10; k++)
      begin
         d = (k < 2) ? {32{k[0]}} : $random(seed);
         xfer(IX_TRIM, 1'b1, d);
         xfer(IX_TRIM, 1'b0, 32'h0);
         check("trim rd", rd, {24'h0, d[7:0]});
         check("trim out", 32'({dither_on_out, int_osc_trim_out}),
            {24'h0, d[7:0]});
      end
      // leave the trim at the factory value, inside the advised range
      xfer(IX_TRIM, 1'b1, 32'(oscctl_pkg::OSCCTL_TRIM_FACTORY));
      // every mode, read-only bit 7 written as 1, bit 3 as 0
      ext_osc_ready_in <= 1'b1;
      for (k = 0; k < 8; k++)
      begin
         d = $random(seed);
         d[7:3] = {1'b1, k[2:0], 1'b0};
         xfer(IX_EXT, 1'b1, d);
         @(posedge clk_in);
         check("mode out", 32'({ext_osc_kind_out, ext_osc_bias_out}),
            {26'h0, d[6:4], d[2:0]});
         repeat (4) @(posedge clk_in);
         base = rises;
         repeat (8)
         begin
            ext_clk_in <= 1'b1;
            repeat (4) @(posedge clk_in);
            ext_clk_in <= 1'b0;
            repeat (4) @(posedge clk_in);
         end
         repeat (4) @(posedge clk_in);
         check("clk rises", rises - base, (k == 2 || k == 6) ? 8 :
            (k == 3 || k == 7) ? 4 : 0);
         xfer(IX_EXT, 1'b0, 32'h0);
         check("ext rd", rd, exp_ext(d[7:0], 1'b1));
      end
      // unmapped word reads zero
      xfer(8'hc0, 1'b1, 32'hff);
      xfer(8'hc0, 1'b0, 32'h0);
      check("unmapped", rd, 32'h0);
      // second reset in mid-run
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("trim rst", 32'({dither_on_out, int_osc_trim_out}),
         32'h40);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      xfer(IX_EXT, 1'b0, 32'h0);
      check("ext rst", rd, 32'h0);
      end_sim;
   end
endmodule
